// ===== rtl/bpc_pkg.sv
package bpc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL0 = 8'h70;
  localparam logic [7:0] IDX_CTRL1 = 8'h72;
  localparam logic [7:0] IDX_PAT_LO = 8'h74;
  localparam logic [7:0] IDX_PAT_HI = 8'h76;
  localparam logic [7:0] IDX_STATUS = 8'h78;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] PAT_RST = 16'h0000;

  // Control word zero fields
  localparam int B_RESYNC = 0;
  localparam int B_LDCNT = 1;
  localparam int F_PSEL_LSB = 2;
  localparam int B_RXINV = 5;
  localparam int B_TXINV = 6;
  localparam int B_BANK = 7;
  localparam int F_LEN_LSB = 8;
  localparam int B_IE_OVF = 13;
  localparam int B_IE_BERR = 14;
  localparam int B_IE_SYNC = 15;
  // Control word one fields
  localparam int B_TLOAD = 0;
  localparam int B_SINGLE = 4;
  localparam int F_RATE_LSB = 5;
  localparam int F_AWC_LSB = 8;

  localparam logic [5:0] REP_LEN_BASE = 6'h11;
  localparam logic [4:0] WORD_LAST = 5'h0f;
  localparam int ERR_CNT_W = 24;

  typedef enum logic [3:0] {
    BPC_PRBS7, BPC_PRBS11, BPC_PRBS15, BPC_QRSS, BPC_REP, BPC_ALT,
    BPC_PRBS9, BPC_PRBS20, BPC_PRBS23, BPC_ILLEGAL
  } bpc_mode_e;

  function automatic bpc_mode_e bpc_decode(input logic bank,
                                           input logic [2:0] sel);
    bpc_decode = BPC_ILLEGAL;
    if (!bank) begin
      case (sel)
        3'h0: bpc_decode = BPC_PRBS7;
        3'h1: bpc_decode = BPC_PRBS11;
        3'h2: bpc_decode = BPC_PRBS15;
        3'h3: bpc_decode = BPC_QRSS;
        3'h4: bpc_decode = BPC_REP;
        3'h5: bpc_decode = BPC_ALT;
        default: bpc_decode = BPC_ILLEGAL;
      endcase
    end else begin
      case (sel)
        3'h0: bpc_decode = BPC_PRBS9;
        3'h1: bpc_decode = BPC_PRBS20;
        3'h2: bpc_decode = BPC_PRBS23;
        default: bpc_decode = BPC_ILLEGAL;
      endcase
    end
  endfunction

  function automatic logic bpc_is_prbs(input bpc_mode_e m);
    bpc_is_prbs = (m != BPC_REP) && (m != BPC_ALT) && (m != BPC_ILLEGAL);
  endfunction

endpackage

// ===== rtl/bpc_err_if.sv
`timescale 1ns/10ps
interface bpc_err_if;
  logic step;
  logic single;
  logic [2:0] rate_code;
  logic flip;
  modport ctl (output step, output single, output rate_code, input flip);
  modport ins (input step, input single, input rate_code, output flip);
endinterface

// ===== rtl/bpc_prbs.sv
`timescale 1ns/10ps
module bpc_prbs
  import bpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [22:0] seed,
  input wire logic step,
  input bpc_mode_e mode,
  output logic bit_out
);
  logic [22:0] sr_reg;
  logic [22:0] sr_next;
  logic fb;

  always_comb begin
    case (mode)
      BPC_PRBS7: fb = sr_reg[6] ^ sr_reg[5];
      BPC_PRBS9: fb = sr_reg[8] ^ sr_reg[4];
      BPC_PRBS11: fb = sr_reg[10] ^ sr_reg[8];
      BPC_PRBS15: fb = sr_reg[14] ^ sr_reg[13];
      BPC_QRSS: fb = sr_reg[19] ^ sr_reg[16];
      BPC_PRBS20: fb = sr_reg[19] ^ sr_reg[2];
      default: fb = sr_reg[22] ^ sr_reg[17];
    endcase
    case (mode)
      BPC_PRBS7: bit_out = sr_reg[6];
      BPC_PRBS9: bit_out = sr_reg[8];
      BPC_PRBS11: bit_out = sr_reg[10];
      BPC_PRBS15: bit_out = sr_reg[14];
      // Long zero runs are broken up so line codes keep timing
      BPC_QRSS: bit_out = sr_reg[19] | ~(|sr_reg[18:5]);
      BPC_PRBS20: bit_out = sr_reg[19];
      default: bit_out = sr_reg[22];
    endcase
    sr_next = sr_reg;
    if (load) begin
      sr_next = seed;
    end else if (step) begin
      sr_next = {sr_reg[21:0], fb};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sr_reg <= '1;
    end else begin
      sr_reg <= sr_next;
    end
  end
endmodule // bpc_prbs

// ===== rtl/bpc_err_insert.sv
`timescale 1ns/10ps
module bpc_err_insert
  import bpc_pkg::*;
#(
  parameter int CNT_W = ERR_CNT_W
)
(
  input wire logic clock,
  input wire logic rst_n,
  bpc_err_if.ins err
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic pend_reg;
  logic pend_next;
  logic [CNT_W-1:0] period;
  logic hit;

  initial begin
    if (CNT_W < ERR_CNT_W) $error("CNT_W too small for ten million");
  end

  always_comb begin
    case (err.rate_code)
      3'h1: period = CNT_W'(10);
      3'h2: period = CNT_W'(100);
      3'h3: period = CNT_W'(1000);
      3'h4: period = CNT_W'(10000);
      3'h5: period = CNT_W'(100000);
      3'h6: period = CNT_W'(1000000);
      default: period = CNT_W'(10000000);
    endcase
    hit = (err.rate_code != 3'h0) && (cnt_reg == period - CNT_W'(1));
    // One inverted bit even when both sources fire together
    err.flip = err.step && (pend_reg || hit);
    cnt_next = cnt_reg;
    if (err.rate_code == 3'h0) begin
      cnt_next = '0;
    end else if (err.step) begin
      cnt_next = hit ? '0 : cnt_reg + CNT_W'(1);
    end
    // A new request in the flip cycle stays pending: set wins
    pend_next = err.single || (pend_reg && !err.step);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      pend_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
    end
  end

  property p_rate_period;
    @(posedge clock) disable iff (!rst_n)
      (err.rate_code == 3'h1 && $stable(err.rate_code) && err.flip
       && !pend_reg) |-> cnt_reg == CNT_W'(9);
  endproperty
  a_rate_period: assert property (p_rate_period)
    else $error("rate error not on tenth bit");

  property p_single_once;
    @(posedge clock) disable iff (!rst_n)
      (err.single && !err.step) |=> pend_reg;
  endproperty
  a_single_once: assert property (p_single_once)
    else $error("single error request lost");

  c_rate_hit: cover property (@(posedge clock) disable iff (!rst_n)
    hit && err.step);
endmodule // bpc_err_insert

// ===== rtl/bpc_top.sv
`timescale 1ns/10ps
// What this block does
// - Receive inversion bit inverts every incoming bit before checking.
// - Transmit inversion bit inverts every outgoing generated bit.
// - Bank bit picks which bank the three-bit pattern select decodes from.
// - Length nibble, LSB first, gives repetitive length as code plus 17.
// - Length nibble ignored while receive checker runs a pseudorandom pattern.
// - Overflow enable lets bit or error counter overflow raise interrupt.
// - Bit error enable lets any detected bit error raise interrupt.
// - Sync enable lets entering or leaving sync raise interrupt.
// - Rising edge of load bit loads generator; software must re-toggle.
// - Rising edge of single error bit corrupts exactly one generated bit.
// - Rate field inserts one error per ten-to-the-n bits, zero none.
// - Alternating mode sends each word count-plus-one times, then repeats.
// - Bank and select codes map to the listed patterns, others illegal.
// - Two pattern halves form one word, bit 0 first sent and received.
module bpc_top
  import bpc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_strobe,
  output logic tx_data,
  input wire logic rx_strobe,
  input wire logic rx_data_in,
  output logic rx_data_out,
  output logic rx_valid,
  output logic [3:0] rx_mode,
  output logic [5:0] rx_rep_len,
  output logic [31:0] rx_pattern,
  output logic rx_resync,
  output logic rx_cnt_latch,
  input wire logic bit_cnt_ovf,
  input wire logic err_cnt_ovf,
  input wire logic bit_err,
  input wire logic sync_in,
  output logic irq
);
  initial begin
    if (ADDR_W < 10) $error("ADDR_W must reach index 0x78");
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Register file over APB
  logic [15:0] ctrl0_reg, ctrl0_next, ctrl1_reg, ctrl1_next;
  logic [15:0] pat_lo_reg, pat_lo_next, pat_hi_reg, pat_hi_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic setup, wr_take, addr_hit;
  logic [7:0] idx;
  logic [15:0] rd_val, status;

  always_comb begin
    setup = psel && !penable;
    idx = paddr[9:2];
    addr_hit = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0) &&
      (idx == IDX_CTRL0 || idx == IDX_CTRL1 || idx == IDX_PAT_LO ||
       idx == IDX_PAT_HI || idx == IDX_STATUS);
    case (idx)
      IDX_CTRL0: rd_val = ctrl0_reg;
      IDX_CTRL1: rd_val = ctrl1_reg;
      IDX_PAT_LO: rd_val = pat_lo_reg;
      IDX_PAT_HI: rd_val = pat_hi_reg;
      IDX_STATUS: rd_val = status;
      default: rd_val = 16'h0000;
    endcase
    // Answer is prepared in setup so pready can come from a flop
    pready_next = setup;
    pslverr_next = setup && !addr_hit;
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = (addr_hit && !pwrite) ? {16'h0000, rd_val} : 32'h0;
    end
    wr_take = psel && penable && pready_reg && pwrite && addr_hit;
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    pat_lo_next = pat_lo_reg;
    pat_hi_next = pat_hi_reg;
    if (wr_take) begin
      case (idx)
        IDX_CTRL0: ctrl0_next = {pwdata[15:13], 1'b0, pwdata[11:0]};
        IDX_CTRL1: ctrl1_next = {pwdata[15:4], 3'h0, pwdata[0]};
        IDX_PAT_LO: pat_lo_next = pwdata[15:0];
        IDX_PAT_HI: pat_hi_next = pwdata[15:0];
        default: ctrl0_next = ctrl0_reg;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl0_reg <= CTRL_RST;
      ctrl1_reg <= CTRL_RST;
      pat_lo_reg <= PAT_RST;
      pat_hi_reg <= PAT_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
      pat_lo_reg <= pat_lo_next;
      pat_hi_reg <= pat_hi_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Control edge detection
  logic tload_prev_reg, single_prev_reg, resync_prev_reg, ldcnt_prev_reg;
  logic load_pulse, single_pulse;
  always_comb begin
    load_pulse = ctrl1_reg[B_TLOAD] && !tload_prev_reg;
    single_pulse = ctrl1_reg[B_SINGLE] && !single_prev_reg;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tload_prev_reg <= 1'b0;
      single_prev_reg <= 1'b0;
      resync_prev_reg <= 1'b0;
      ldcnt_prev_reg <= 1'b0;
    end else begin
      tload_prev_reg <= ctrl1_reg[B_TLOAD];
      single_prev_reg <= ctrl1_reg[B_SINGLE];
      resync_prev_reg <= ctrl0_reg[B_RESYNC];
      ldcnt_prev_reg <= ctrl0_reg[B_LDCNT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern generator
  bpc_mode_e mode_reg, mode_next;
  logic [31:0] word_reg, word_next;
  logic [4:0] pos_reg, pos_next;
  logic [5:0] len_reg, len_next;
  logic phase_reg, phase_next;
  logic [7:0] rep_reg, rep_next;
  logic tx_data_reg, tx_data_next;
  logic raw_bit, prbs_bit, prbs_step;
  bpc_err_if err_bus();

  bpc_prbs u_prbs (
    .clock(clock),
    .rst_n(rst_n),
    .load(load_pulse),
    .seed(word_reg[22:0]),
    .step(prbs_step),
    .mode(mode_reg),
    .bit_out(prbs_bit)
  );

  bpc_err_insert u_err (
    .clock(clock),
    .rst_n(rst_n),
    .err(err_bus.ins)
  );

  always_comb begin
    err_bus.step = tx_strobe;
    err_bus.single = single_pulse;
    err_bus.rate_code = ctrl1_reg[F_RATE_LSB +: 3];
    prbs_step = tx_strobe && bpc_is_prbs(mode_reg) && !load_pulse;
    case (mode_reg)
      BPC_REP: raw_bit = word_reg[pos_reg];
      BPC_ALT: raw_bit = phase_reg ? word_reg[5'h10 + pos_reg] :
        word_reg[pos_reg];
      BPC_ILLEGAL: raw_bit = 1'b0;
      default: raw_bit = prbs_bit;
    endcase
    mode_next = mode_reg;
    word_next = word_reg;
    pos_next = pos_reg;
    len_next = len_reg;
    phase_next = phase_reg;
    rep_next = rep_reg;
    if (load_pulse) begin
      // Pattern, mode and length are frozen here until the next load
      mode_next = bpc_decode(ctrl0_reg[B_BANK],
        ctrl0_reg[F_PSEL_LSB +: 3]);
      word_next = {pat_hi_reg, pat_lo_reg};
      len_next = REP_LEN_BASE + {2'b00, ctrl0_reg[F_LEN_LSB +: 4]};
      pos_next = 5'h00;
      phase_next = 1'b0;
      rep_next = 8'h00;
    end else if (tx_strobe) begin
      if (mode_reg == BPC_REP) begin
        pos_next = ({1'b0, pos_reg} == len_reg - 6'h01) ? 5'h00 :
          pos_reg + 5'h01;
      end else if (mode_reg == BPC_ALT) begin
        pos_next = (pos_reg == WORD_LAST) ? 5'h00 : pos_reg + 5'h01;
        if (pos_reg == WORD_LAST) begin
          if (rep_reg == ctrl1_reg[F_AWC_LSB +: 8]) begin
            rep_next = 8'h00;
            phase_next = !phase_reg;
          end else begin
            rep_next = rep_reg + 8'h01;
          end
        end
      end
    end
    tx_data_next = tx_data_reg;
    if (tx_strobe) begin
      // Error first, then line inversion, so inversion cannot hide it
      tx_data_next = (raw_bit ^ err_bus.flip) ^
        ctrl0_reg[B_TXINV];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_reg <= BPC_PRBS7;
      word_reg <= 32'h0000_0000;
      pos_reg <= 5'h00;
      len_reg <= REP_LEN_BASE;
      phase_reg <= 1'b0;
      rep_reg <= 8'h00;
      tx_data_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      word_reg <= word_next;
      pos_reg <= pos_next;
      len_reg <= len_next;
      phase_reg <= phase_next;
      rep_reg <= rep_next;
      tx_data_reg <= tx_data_next;
    end
  end

  assign tx_data = tx_data_reg;

  ////////////////////////////////////////////////////////////////////////
  // Receive side setup and interrupt
  logic rx_data_reg, rx_valid_reg, irq_reg, sync_prev_reg;
  logic rx_resync_reg, rx_cnt_latch_reg;
  logic [3:0] rx_mode_reg;
  logic [5:0] rx_len_reg;
  logic [31:0] rx_pat_reg;
  logic rx_data_next, irq_next;
  logic [5:0] rx_len_next;
  bpc_mode_e rx_mode_dec;

  always_comb begin
    rx_mode_dec = bpc_decode(ctrl0_reg[B_BANK], ctrl0_reg[F_PSEL_LSB +: 3]);
    rx_data_next = rx_strobe ? (rx_data_in ^ ctrl0_reg[B_RXINV]) :
      rx_data_reg;
    // Checker sees length zero in pseudorandom modes
    rx_len_next = bpc_is_prbs(rx_mode_dec) ? 6'h00 :
      REP_LEN_BASE + {2'b00, ctrl0_reg[F_LEN_LSB +: 4]};
    irq_next = ((bit_cnt_ovf || err_cnt_ovf) && ctrl0_reg[B_IE_OVF]) ||
      (bit_err && ctrl0_reg[B_IE_BERR]) ||
      ((sync_in ^ sync_prev_reg) && ctrl0_reg[B_IE_SYNC]);
    status = {rep_reg, 2'b00, mode_reg, phase_reg, sync_in};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_data_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
      irq_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
      rx_resync_reg <= 1'b0;
      rx_cnt_latch_reg <= 1'b0;
      rx_mode_reg <= 4'h0;
      rx_len_reg <= 6'h00;
      rx_pat_reg <= 32'h0000_0000;
    end else begin
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_strobe;
      irq_reg <= irq_next;
      sync_prev_reg <= sync_in;
      rx_resync_reg <= ctrl0_reg[B_RESYNC] && !resync_prev_reg;
      rx_cnt_latch_reg <= ctrl0_reg[B_LDCNT] && !ldcnt_prev_reg;
      rx_mode_reg <= rx_mode_dec;
      rx_len_reg <= rx_len_next;
      rx_pat_reg <= {pat_hi_reg, pat_lo_reg};
    end
  end

  assign rx_data_out = rx_data_reg;
  assign rx_valid = rx_valid_reg;
  assign irq = irq_reg;
  assign rx_resync = rx_resync_reg;
  assign rx_cnt_latch = rx_cnt_latch_reg;
  assign rx_mode = rx_mode_reg;
  assign rx_rep_len = rx_len_reg;
  assign rx_pattern = rx_pat_reg;
  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rx_inv;
    rx_strobe |=> rx_data_out == $past(rx_data_in ^ ctrl0_reg[B_RXINV]);
  endproperty
  a_rx_inv: assert property (p_rx_inv)
    else $error("receive bit not inverted as enabled");
  property p_tx_inv;
    (tx_strobe && !err_bus.flip) |=>
      tx_data == ($past(raw_bit) ^ $past(ctrl0_reg[B_TXINV]));
  endproperty
  a_tx_inv: assert property (p_tx_inv)
    else $error("transmit inversion wrong");
  property p_bank1;
    (load_pulse && ctrl0_reg[B_BANK] && ctrl0_reg[F_PSEL_LSB +: 3] == 3'h2)
      |=> mode_reg == BPC_PRBS23;
  endproperty
  a_bank1: assert property (p_bank1)
    else $error("bank one select not honoured");
  property p_len;
    load_pulse |=> len_reg == 6'd17 + $past(ctrl0_reg[11:8]);
  endproperty
  a_len: assert property (p_len)
    else $error("repetitive length not code plus 17");
  property p_rx_len_prbs;
    bpc_is_prbs(rx_mode_dec) |=> rx_rep_len == 6'h00;
  endproperty
  a_rx_len_prbs: assert property (p_rx_len_prbs)
    else $error("length used in pseudorandom mode");
  property p_irq;
    (bit_err && ctrl0_reg[B_IE_BERR]) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("bit error interrupt wrong");
  property p_irq_masked;
    ctrl0_reg[15:13] == 3'h0 |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("masked interrupt raised");
  property p_sync_irq;
    (ctrl0_reg[B_IE_SYNC] && $changed(sync_in)) |=> irq;
  endproperty
  a_sync_irq: assert property (p_sync_irq)
    else $error("sync change missed");
  property p_load_once;
    load_pulse |=> !load_pulse;
  endproperty
  a_load_once: assert property (p_load_once)
    else $error("held load bit reloaded");
  property p_alt_flip;
    (mode_reg == BPC_ALT && !$past(load_pulse) && $changed(phase_reg)) |->
      $past(pos_reg) == WORD_LAST && $past(rep_reg) == $past(ctrl1_reg[15:8]);
  endproperty
  a_alt_flip: assert property (p_alt_flip)
    else $error("alternating word switched early");
  c_load: cover property (load_pulse);
  c_alt: cover property (mode_reg == BPC_ALT && phase_reg);
  c_wr: cover property (wr_take);
endmodule // bpc_top

// ===== tb/bpc_line_model.sv
`timescale 1ns/10ps
module bpc_line_model #(
  parameter int GAP = 2
)
(
  input wire logic clock,
  input wire logic run,
  input wire logic clr,
  input wire logic tx_data,
  input wire logic rx_valid,
  input wire logic rx_data_out,
  output logic tx_strobe,
  output logic rx_strobe,
  output logic rx_data_in,
  output logic [63:0] cap,
  output logic [63:0] rcap,
  output int n_cap
);
  int gap_cnt = 0;
  int n_rx = 0;
  logic strobe_d = 1'b0;
  initial begin
    tx_strobe = 1'b0;
    rx_strobe = 1'b0;
    rx_data_in = 1'b0;
    n_cap = 0;
  end
  // Sparse strobes force the generator to hold its bit in between
  always @(posedge clock) begin
    gap_cnt <= (gap_cnt + 1) % GAP;
    tx_strobe <= run && (gap_cnt == 0);
    strobe_d <= tx_strobe;
    rx_strobe <= strobe_d;
    // Idle line toggles so a stale bit never passes for data
    rx_data_in <= strobe_d ? tx_data : ~rx_data_in;
    if (clr) begin
      n_cap <= 0;
      n_rx <= 0;
    end else begin
      if (strobe_d && n_cap < 64) begin
        cap[n_cap] <= tx_data;
        n_cap <= n_cap + 1;
      end
      if (rx_valid && n_rx < 64) begin
        rcap[n_rx] <= rx_data_out;
        n_rx <= n_rx + 1;
      end
    end
  end
endmodule // bpc_line_model

// ===== tb/tb_bpc_top.sv
`timescale 1ns/10ps
module tb_bpc_top
  import bpc_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rx_pattern;
  logic pready, pslverr, tx_strobe, tx_data, rx_strobe, rx_data_in;
  logic rx_data_out, rx_valid, rx_resync, rx_cnt_latch, irq;
  logic [3:0] rx_mode;
  logic [5:0] rx_rep_len;
  logic bit_cnt_ovf = 1'b0;
  logic err_cnt_ovf = 1'b0;
  logic bit_err = 1'b0;
  logic sync_in = 1'b0;
  logic run = 1'b0;
  logic clr = 1'b0;
  logic [63:0] cap, rcap;
  int n_cap;
  int err_count = 0;
  int n_tests = 0;

  always #2 clock = ~clock;

  bpc_top dut (
    .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_strobe(tx_strobe),
    .tx_data(tx_data), .rx_strobe(rx_strobe), .rx_data_in(rx_data_in),
    .rx_data_out(rx_data_out), .rx_valid(rx_valid), .rx_mode(rx_mode),
    .rx_rep_len(rx_rep_len), .rx_pattern(rx_pattern),
    .rx_resync(rx_resync), .rx_cnt_latch(rx_cnt_latch),
    .bit_cnt_ovf(bit_cnt_ovf), .err_cnt_ovf(err_cnt_ovf),
    .bit_err(bit_err), .sync_in(sync_in), .irq(irq)
  );

  bpc_line_model #(.GAP(3)) line (
    .clock(clock), .run(run), .clr(clr), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data_out(rx_data_out), .tx_strobe(tx_strobe),
    .rx_strobe(rx_strobe), .rx_data_in(rx_data_in), .cap(cap),
    .rcap(rcap), .n_cap(n_cap)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [7:0] idx,
                     input logic [15:0] wd, output logic [31:0] rdat,
                     output logic serr);
    int n;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      err_count++;
      end_of_test();
    end
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 16'h0000, r, e);
    chk(r, exp);
    chk(32'(e), 32'(exp_err));
  endtask

  // Falling write first, so every load is a genuine rising edge
  task automatic load(input logic [15:0] c1);
    wr(IDX_CTRL1, c1);
    wr(IDX_CTRL1, c1 | 16'h0001);
  endtask

  task automatic send(input int nb);
    int n;
    clr <= 1'b1;
    // Two edges, so the cleared count is seen before it is polled
    repeat (2) @(posedge clock);
    clr <= 1'b0;
    run <= 1'b1;
    n = 0;
    while (n_cap < nb && n < 1000) begin
      @(posedge clock);
      n++;
    end
    run <= 1'b0;
    if (n >= 1000) begin
      err_count++;
      end_of_test();
    end
    repeat (8) @(posedge clock);
  endtask

  function automatic logic [63:0] gen_exp(input logic [31:0] p,
      input int len, input int alt_word_count, input logic inv);
    for (int k = 0; k < 64; k++) begin
      if (alt_word_count < 0) gen_exp[k] = p[k % len] ^ inv;
      else gen_exp[k] = p[((k / 16 / (alt_word_count + 1)) % 2) * 16 + k % 16] ^ inv;
    end
  endfunction

  // Counts sent-bit errors; a wrong looped-back bit weighs 100
  task automatic cmp_bits(input logic [63:0] e, input int nb, input int ne,
                          input logic ri);
    int d;
    d = 0;
    for (int k = 0; k < nb; k++) begin
      d += int'(cap[k] !== e[k]);
      if (rcap[k] !== (cap[k] ^ ri)) d += 100;
    end
    chk(32'(d), 32'(ne));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int m;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd_chk(IDX_CTRL0, {16'h0000, CTRL_RST}, 1'b0);
    rd_chk(IDX_PAT_HI, {16'h0000, PAT_RST}, 1'b0);
    rd_chk(8'h71, 32'h0000_0000, 1'b1);
    wr(IDX_CTRL0, 16'hFFFC);
    rd_chk(IDX_CTRL0, 32'h0000_EFFC, 1'b0);
    // Single error bit left low, else a stale error lands in the next send
    wr(IDX_CTRL1, 16'hFFEE);
    rd_chk(IDX_CTRL1, 32'h0000_FFE0, 1'b0);
    wr(IDX_CTRL0, 16'h0003);
    #1 chk(32'({rx_resync, rx_cnt_latch}), 32'h0000_0003);
    @(posedge clock);
    #1 chk(32'({rx_resync, rx_cnt_latch}), 32'h0000_0000);
    @(posedge clock);
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      wr(IDX_CTRL0, {4'h0, 4'(i), i[3], 2'b00, i[2:0], 2'b00});
      m = i[3] ? (i[2:0] < 3 ? 6 + i[2:0] : 9) : (i[2:0] < 6 ? i[2:0] : 9);
      repeat (2) @(posedge clock);
      chk(32'(rx_mode), 32'(m));
      if (m inside {[0:3], [6:8]}) chk(32'(rx_rep_len), 0);
    end
    for (int l = 0; l < 16; l++) begin
      wr(IDX_CTRL0, {4'h0, 4'(l), 8'h10});
      repeat (2) @(posedge clock);
      chk(32'(rx_rep_len), 32'(17 + l));
    end
    $display("decode test done");
    wr(IDX_PAT_LO, 16'hB5AD);
    wr(IDX_PAT_HI, 16'h5AD6);
    repeat (2) @(posedge clock);
    chk(rx_pattern, 32'h5AD6_B5AD);
    for (int v = 0; v < 4; v++) begin
      wr(IDX_CTRL0, {8'h0D, 1'b0, 2'(v), 5'h10});
      load(16'h0000);
      send(40);
      cmp_bits(gen_exp(32'h5AD6_B5AD, 30, -1, v[1]), 40, 0, v[0]);
    end
    wr(IDX_CTRL0, 16'h0D50);
    load(16'h0000);
    wr(IDX_CTRL1, 16'h0011);
    send(40);
    cmp_bits(gen_exp(32'h5AD6_B5AD, 30, -1, 1), 40, 1, 0);
    load(16'h0010);
    send(40);
    cmp_bits(gen_exp(32'h5AD6_B5AD, 30, -1, 1), 40, 0, 0);
    load(16'h0020);
    send(40);
    cmp_bits(gen_exp(32'h5AD6_B5AD, 30, -1, 1), 40, 4, 0);
    $display("repetitive test done");
    wr(IDX_PAT_LO, 16'h00FF);
    wr(IDX_PAT_HI, 16'hF0F0);
    wr(IDX_CTRL0, 16'h0014);
    load(16'h0100);
    send(64);
    cmp_bits(gen_exp(32'hF0F0_00FF, 32, 1, 0), 64, 0, 0);
    $display("alternating test done");
    wr(IDX_CTRL0, 16'h0088);
    load(16'h0000);
    rd_chk(IDX_STATUS, 32'h0000_0020, 1'b0);
    $display("bank one test done");
    for (int i = 0; i < 3; i++) begin
      wr(IDX_CTRL0, 16'h2000 << i);
      for (int j = 0; j < 4; j++) begin
        bit_cnt_ovf <= (j == 0);
        err_cnt_ovf <= (j == 1);
        bit_err <= (j == 2);
        if (j == 3) sync_in <= ~sync_in;
        @(posedge clock);
        bit_cnt_ovf <= 1'b0;
        err_cnt_ovf <= 1'b0;
        bit_err <= 1'b0;
        #1 chk(32'(irq), 32'(i == (j < 2 ? 0 : j - 1)));
        @(posedge clock);
      end
    end
    $display("interrupt test done");
    end_of_test();
  end
endmodule // tb_bpc_top
